/* pkg/sfr_pkg.sv */
// Constants, types and encodings for the serial flash reset block.
// Assumes one 25 MHz system clock and pins already synchronous to it.
package sfr_pkg;

  // Configuration area geometry
  localparam int CFG_DEPTH = 8;
  localparam int CFG_WIDTH = 16;
  localparam logic [15:0] CFG_RESET_WORD = 16'h5A00;

  // Commands
  localparam logic [7:0] CMD_WR_STATUS = 8'h01;
  localparam logic [7:0] CMD_START_OP  = 8'h20;
  localparam logic [7:0] CMD_RST_EN    = 8'h66;
  localparam logic [7:0] CMD_RST       = 8'h99;

  // Status field positions inside working word 0
  localparam int STAT_HOLD_SEL = 0;
  localparam int STAT_QUAD_EN  = 1;

  // In-band reset: pulse count and serial input level per pulse
  localparam logic [2:0] INBAND_PULSES = 3'h4;
  localparam logic [3:0] INBAND_SI     = 4'hA;

  // Internal engine run length in cycles
  localparam logic [7:0] OP_CYCLES = 8'h10;

  typedef enum {ST_LOAD, ST_READY} sfr_state_type;
  typedef enum {ENG_IDLE, ENG_BUSY} sfr_eng_type;

  // Host-facing pins, all inputs seen by the device
  typedef struct packed {
    logic       csN;
    logic       sck;
    logic [3:0] io;
  } sfr_pins_type;

endpackage

/* design/sfr_cfg_mem.sv */
// Nonvolatile configuration area model with a registered read port.
// Assumes reads and writes come from one owner in the same clock domain.
`timescale 1ns/1ns
module sfr_cfg_mem #(
  parameter int WIDTH = sfr_pkg::CFG_WIDTH,
  parameter int DEPTH = sfr_pkg::CFG_DEPTH,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic             ce,
  input  wire logic [AW-1:0]    rdAddr,
  output logic      [WIDTH-1:0] rdData,
  input  wire logic             wrEn,
  input  wire logic [AW-1:0]    wrAddr,
  input  wire logic [WIDTH-1:0] wrData
);

  logic [WIDTH-1:0] mem_reg [DEPTH];

  // One word per entry, factory contents at power-on
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_word
    always_ff @(posedge sys_clk)
    begin
      if (!resetn)
        mem_reg[i] <= WIDTH'(sfr_pkg::CFG_RESET_WORD + 16'(i));
      else if (ce && wrEn && wrAddr == AW'(i))
        mem_reg[i] <= wrData;
    end
  end

  // Registered read data
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      rdData <= '0;
    else if (ce)
      rdData <= mem_reg[rdAddr];
  end

endmodule

/* design/sfr_reset_ctrl.sv */
// Device-side reset handling: pin, in-band and two-command software reset.
// Assumes pins are synchronous to sys_clk; resetn models power-on reset.
`timescale 1ns/1ns
module sfr_reset_ctrl #(
  parameter int WIDTH = sfr_pkg::CFG_WIDTH,
  parameter int DEPTH = sfr_pkg::CFG_DEPTH,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic                 sys_clk,
  input  wire logic                 resetn,
  input  wire logic                 ce,
  input  sfr_pkg::sfr_pins_type     pins,
  input  wire logic                 engineStall,
  output logic                      devReady,
  output logic                      quadMode,
  output logic                      holdActive,
  output logic                      engineBusy,
  output logic                      fullResetPulse,
  output logic                      softResetPulse,
  output logic [WIDTH-1:0]          workWord0
);

  sfr_pkg::sfr_state_type state_reg, state_next;
  sfr_pkg::sfr_eng_type   eng_reg, eng_next;
  logic [AW:0]      loadIdx_reg, loadIdx_next;
  logic             loadPend_reg, loadPend_next, wrPend_reg, wrPend_next;
  logic [WIDTH-1:0] work_reg [DEPTH], work_next [DEPTH];
  logic [7:0]       shift_reg, shift_next, opCnt_reg, opCnt_next, byteVal;
  logic [3:0]       bitCnt_reg, bitCnt_next, bitStep;
  logic             rstEn_reg, rstEn_next, sckPrev_reg, csPrev_reg;
  logic [2:0]       ibCnt_reg, ibCnt_next;
  logic             ibSi_reg, ibSi_next, ibSck_reg, ibSck_next;
  logic             ibHit, pinReset, fullReq, softReq, memWr;
  logic             sckRise, csFall, csRise, hold, quad, byteDone;
  logic [WIDTH-1:0] rdData, memWrData;
  sfr_cfg_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_cfg (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .ce      (ce),
    .rdAddr  (loadIdx_reg[AW-1:0]),
    .rdData  (rdData),
    .wrEn    (memWr),
    .wrAddr  ('0),
    .wrData  (memWrData)
  );

  // Pin decode and edges
  always_comb
  begin
    quad     = work_reg[0][sfr_pkg::STAT_QUAD_EN];
    sckRise  = pins.sck && !sckPrev_reg;
    csFall   = !pins.csN && csPrev_reg;
    csRise   = pins.csN && !csPrev_reg;
    hold     = work_reg[0][sfr_pkg::STAT_HOLD_SEL] && !quad && !pins.io[3];
    pinReset = !work_reg[0][sfr_pkg::STAT_HOLD_SEL] && !quad
               && !pins.io[3];
  end

  // In-band pattern detector, independent of the command path
  always_comb
  begin
    ibCnt_next = ibCnt_reg;
    ibSi_next  = ibSi_reg;
    ibSck_next = ibSck_reg;
    ibHit      = 1'b0;
    if (csFall)
    begin
      ibSi_next  = pins.io[0];
      ibSck_next = 1'b0;
    end
    if (sckRise)
    begin
      ibSck_next = 1'b1;
      ibCnt_next = '0;
    end
    else if (csRise)
    begin
      if (!ibSck_reg && ibSi_reg == sfr_pkg::INBAND_SI[ibCnt_reg[1:0]])
      begin
        if (ibCnt_reg == sfr_pkg::INBAND_PULSES - 3'h1)
        begin
          ibHit      = 1'b1;
          ibCnt_next = '0;
        end
        else
          ibCnt_next = ibCnt_reg + 3'h1;
      end
      else
        ibCnt_next = '0;
    end
  end

  // Main sequencer, command decoder and internal engine
  always_comb
  begin
    state_next    = state_reg;
    eng_next      = eng_reg;
    loadIdx_next  = loadIdx_reg;
    loadPend_next = 1'b0;
    work_next     = work_reg;
    shift_next    = shift_reg;
    bitCnt_next   = bitCnt_reg;
    rstEn_next    = rstEn_reg;
    wrPend_next   = wrPend_reg;
    opCnt_next    = opCnt_reg;
    memWr         = 1'b0;
    memWrData     = work_reg[0];
    softReq       = 1'b0;
    byteDone      = 1'b0;
    bitStep       = quad ? 4'h4 : 4'h1;
    byteVal       = quad ? {shift_reg[3:0], pins.io}
                         : {shift_reg[6:0], pins.io[0]};
    fullReq       = pinReset || ibHit;
    // Engine runs unless stalled by a fault
    if (eng_reg == sfr_pkg::ENG_BUSY && !engineStall)
    begin
      if (opCnt_reg == 8'h01)
        eng_next = sfr_pkg::ENG_IDLE;
      opCnt_next = opCnt_reg - 8'h01;
    end
    case (state_reg)
      sfr_pkg::ST_LOAD:
      begin
        // Copy configuration words into working registers
        if (loadPend_reg)
          work_next[loadIdx_reg[AW-1:0] - AW'(1)] = rdData;
        if (loadIdx_reg < (AW+1)'(DEPTH))
        begin
          loadIdx_next  = loadIdx_reg + (AW+1)'(1);
          loadPend_next = 1'b1;
        end
        else if (!loadPend_reg)
          state_next = sfr_pkg::ST_READY;
      end
      sfr_pkg::ST_READY:
      begin
        if (pins.csN)
        begin
          bitCnt_next = '0;
          wrPend_next = 1'b0;
        end
        else if (sckRise && !hold)
        begin
          shift_next  = byteVal;
          bitCnt_next = bitCnt_reg + bitStep;
          if (bitCnt_reg + bitStep == 4'h8)
          begin
            byteDone    = 1'b1;
            bitCnt_next = '0;
          end
        end
        if (byteDone && wrPend_reg)
        begin
          // Status byte: working copy and nonvolatile copy
          work_next[0][1:0] = byteVal[1:0];
          memWrData         = {work_reg[0][WIDTH-1:2], byteVal[1:0]};
          memWr             = 1'b1;
          wrPend_next       = 1'b0;
        end
        else if (byteDone)
        begin
          rstEn_next = (byteVal == sfr_pkg::CMD_RST_EN);
          if (byteVal == sfr_pkg::CMD_RST && rstEn_reg)
            softReq = 1'b1;
          else if (byteVal == sfr_pkg::CMD_WR_STATUS)
            wrPend_next = 1'b1;
          else if (byteVal == sfr_pkg::CMD_START_OP
                   && eng_reg == sfr_pkg::ENG_IDLE)
          begin
            eng_next   = sfr_pkg::ENG_BUSY;
            opCnt_next = sfr_pkg::OP_CYCLES;
          end
        end
        if (softReq)
        begin
          // Restart engine and decoder, keep working registers
          eng_next    = sfr_pkg::ENG_IDLE;
          opCnt_next  = '0;
          rstEn_next  = 1'b0;
          wrPend_next = 1'b0;
        end
      end
      default: state_next = sfr_pkg::ST_LOAD;
    endcase
    if (fullReq)
    begin
      // Full reset: everything except the in-band detector and pin edge history restarts and reloads
      state_next   = sfr_pkg::ST_LOAD;
      loadIdx_next = '0;
      loadPend_next = 1'b0;
      eng_next     = sfr_pkg::ENG_IDLE;
      opCnt_next   = '0;
      shift_next   = '0;
      bitCnt_next  = '0;
      rstEn_next   = 1'b0;
      wrPend_next  = 1'b0;
      memWr        = 1'b0;
      softReq      = 1'b0;
    end
  end

  // State registers and outputs
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      state_reg      <= sfr_pkg::ST_LOAD;
      eng_reg        <= sfr_pkg::ENG_IDLE;
      loadIdx_reg    <= '0;
      loadPend_reg   <= 1'b0;
      for (int i = 0; i < DEPTH; i++)
        work_reg[i] <= '0;
      shift_reg      <= '0;
      bitCnt_reg     <= '0;
      rstEn_reg      <= 1'b0;
      wrPend_reg     <= 1'b0;
      opCnt_reg      <= '0;
      sckPrev_reg    <= 1'b0;
      csPrev_reg     <= 1'b1;
      ibCnt_reg      <= '0;
      ibSi_reg       <= 1'b0;
      ibSck_reg      <= 1'b0;
      devReady       <= 1'b0;
      quadMode       <= 1'b0;
      holdActive     <= 1'b0;
      engineBusy     <= 1'b0;
      fullResetPulse <= 1'b0;
      softResetPulse <= 1'b0;
      workWord0      <= '0;
    end
    else if (ce)
    begin
      state_reg      <= state_next;
      eng_reg        <= eng_next;
      loadIdx_reg    <= loadIdx_next;
      loadPend_reg   <= loadPend_next;
      work_reg       <= work_next;
      shift_reg      <= shift_next;
      bitCnt_reg     <= bitCnt_next;
      rstEn_reg      <= rstEn_next;
      wrPend_reg     <= wrPend_next;
      opCnt_reg      <= opCnt_next;
      sckPrev_reg    <= pins.sck;
      csPrev_reg     <= pins.csN;
      ibCnt_reg      <= ibCnt_next;
      ibSi_reg       <= ibSi_next;
      ibSck_reg      <= ibSck_next;
      devReady       <= (state_next == sfr_pkg::ST_READY);
      quadMode       <= work_next[0][sfr_pkg::STAT_QUAD_EN];
      holdActive     <= hold && state_next == sfr_pkg::ST_READY;
      engineBusy     <= (eng_next == sfr_pkg::ENG_BUSY);
      fullResetPulse <= fullReq;
      softResetPulse <= softReq;
      workWord0      <= work_next[0];
    end
  end

  // Checks on reset behaviour
  a_pin_full_reset: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    ce && pinReset |=> fullResetPulse && !devReady)
    else $error("pin reset did not restart device");
  a_hold_no_reset: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    ce && hold && !ibHit |=> !fullResetPulse)
    else $error("hold function caused a reset");
  a_quad_no_pin: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    ce && quad && !ibHit |=> !fullResetPulse)
    else $error("reset pin acted in quad mode");
  a_inband_reset: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    ce && ibHit |=> fullResetPulse && state_reg == sfr_pkg::ST_LOAD)
    else $error("in-band pattern did not reset");
  a_full_reload: assert property (
    @(posedge sys_clk) disable iff (!resetn || !ce)
    fullResetPulse && !fullReq |-> !devReady ##[1:12] devReady)
    else $error("full reset reload did not finish");
  // A pulse frozen by a low enable must not be judged against stale history
  a_soft_pair: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    $past(ce) && softResetPulse
    |-> $past(rstEn_reg) && $past(byteVal) == 8'h99)
    else $error("software reset without enable pair");
  a_soft_iface: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    ce && state_reg != sfr_pkg::ST_READY |=> !softResetPulse)
    else $error("software reset while interface down");
  a_soft_restart: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    softResetPulse |-> !engineBusy && devReady)
    else $error("software reset left engine busy");
  a_soft_keeps: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    softResetPulse |-> workWord0 == $past(workWord0))
    else $error("software reset altered working word");

endmodule

/* bench/sfr_host_model.sv */
// Host flash controller model: drives select, serial clock and data lines.
// Assumes the bench calls its tasks; every line moves on the falling edge.
`timescale 1ns/1ns
module sfr_host_model #(
  parameter int SELECT_WAIT = 8
) (
  input  wire logic             sys_clk,
  output sfr_pkg::sfr_pins_type pins
);
  // Idle: deselected, clock low, reset pin and serial input high
  initial pins = '{csN: 1'b1, sck: 1'b0, io: 4'h9};

  // Supply-to-select wait before the first access, shortened
  task power_wait();
    repeat (SELECT_WAIT) @(negedge sys_clk);
  endtask

  // One byte MSB first; quad sends two nibbles on io[3:0]
  task send_byte(input logic [7:0] b, input logic quad);
    int i;
    @(negedge sys_clk);
    pins.csN = 1'b0;
    for (i = 0; i < (quad ? 2 : 8); i++)
    begin
      @(negedge sys_clk);
      pins.sck = 1'b0;
      if (quad)
        pins.io = b[7-4*i -: 4];
      else
        pins.io[0] = b[7-i];
      @(negedge sys_clk);
      pins.sck = 1'b1;
    end
  endtask

  // End of frame: clock stands still, lines back to idle
  task deselect();
    @(negedge sys_clk);
    pins = '{csN: 1'b1, sck: 1'b0, io: 4'h9};
  endtask

  // Shared io[3] reset pin level, preferred after a suspected glitch
  task set_reset_pin(input logic v);
    @(negedge sys_clk);
    pins.io[3] = v;
  endtask

  // In-band reset; breakIt raises the clock on the last pulse to spoil it,
  // so no partial count is left behind to complete a later pattern early
  task inband_reset(input logic breakIt);
    int i;
    for (i = 0; i < int'(sfr_pkg::INBAND_PULSES); i++)
    begin
      @(negedge sys_clk);
      pins.csN = 1'b0;
      pins.io[0] = sfr_pkg::INBAND_SI[i];
      @(negedge sys_clk);
      pins.sck = breakIt && (i == 3);
      @(negedge sys_clk);
      pins.csN = 1'b1;
      pins.sck = 1'b0;
    end
  endtask
endmodule

/* bench/test_sfr_reset_ctrl.sv */
// Testbench for the reset block: power-up, in-band, pin and command resets.
// Assumes the host model owns the pins; the bench drives the other inputs.
`timescale 1ns/1ns
module test_sfr_reset_ctrl;
  logic                  sys_clk;
  logic                  resetn;
  logic                  ce;
  logic                  engineStall;
  sfr_pkg::sfr_pins_type pins;
  logic                  devReady;
  logic                  quadMode;
  logic                  holdActive;
  logic                  engineBusy;
  logic                  fullResetPulse;
  logic                  softResetPulse;
  logic [15:0]           workWord0;
  logic                  seenFull;
  logic                  seenSoft;
  logic                  seenDrop;
  int                    n_errors;
  int                    total_checks;
  int                    cycles;

  // Device and host
  sfr_reset_ctrl i_dut (
    .sys_clk(sys_clk), .resetn(resetn), .ce(ce), .pins(pins),
    .engineStall(engineStall), .devReady(devReady), .quadMode(quadMode),
    .holdActive(holdActive), .engineBusy(engineBusy),
    .fullResetPulse(fullResetPulse), .softResetPulse(softResetPulse),
    .workWord0(workWord0)
  );
  sfr_host_model i_host (.sys_clk(sys_clk), .pins(pins));

  // 25 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Hang guard
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      $display("BAD %0t timeout", $time);
      give_verdict();
    end
  end

  task check(input logic [15:0] got, input logic [15:0] exp, input string s);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t %s got %h", $time, s, got);
    end
  endtask

  // Record pulses and ready drops over n cycles
  task watch(input int n);
    seenFull = 1'b0;
    seenSoft = 1'b0;
    seenDrop = 1'b0;
    repeat (n)
    begin
      @(negedge sys_clk);
      seenFull |= (fullResetPulse === 1'b1);
      seenSoft |= (softResetPulse === 1'b1);
      seenDrop |= (devReady === 1'b0);
    end
  endtask

  task wait_ready(input int n);
    int k;
    k = 0;
    while (devReady !== 1'b1 && k < n)
    begin
      @(negedge sys_clk);
      k++;
    end
    check(devReady, 1'b1, "ready");
  endtask

  task wr_status(input logic [7:0] v);
    i_host.send_byte(sfr_pkg::CMD_WR_STATUS, 1'b0);
    i_host.send_byte(v, 1'b0);
    i_host.deselect();
    repeat (2) @(negedge sys_clk);
  endtask

  task t_power_up();
    check(devReady, 1'b0, "ready in load");
    wait_ready(12);
    check(workWord0, sfr_pkg::CFG_RESET_WORD, "word0");
    check(quadMode, 1'b0, "quad");
    i_host.power_wait();
  endtask

  task t_inband();
    i_host.inband_reset(1'b1);
    watch(4);
    check(seenFull, 1'b0, "spoilt in-band");
    i_host.inband_reset(1'b0);
    watch(4);
    check(seenFull, 1'b1, "in-band");
    check(seenDrop, 1'b1, "in-band reload");
    wait_ready(12);
  endtask

  task t_soft();
    engineStall = 1'b1;
    i_host.send_byte(sfr_pkg::CMD_START_OP, 1'b0);
    repeat (24) @(negedge sys_clk);
    check(engineBusy, 1'b1, "hung");
    i_host.send_byte(sfr_pkg::CMD_RST, 1'b0);
    watch(4);
    check(seenSoft, 1'b0, "lone reset");
    i_host.send_byte(sfr_pkg::CMD_RST_EN, 1'b0);
    i_host.send_byte(sfr_pkg::CMD_RST, 1'b0);
    watch(4);
    i_host.deselect();
    check(seenSoft, 1'b1, "soft reset");
    check(engineBusy, 1'b0, "engine");
    check(seenDrop, 1'b0, "no reload");
    check(workWord0, sfr_pkg::CFG_RESET_WORD, "kept");
    engineStall = 1'b0;
  endtask

  task t_pin();
    i_host.set_reset_pin(1'b0);
    watch(3);
    check(seenFull, 1'b1, "pin reset");
    check(seenDrop, 1'b1, "pin reload");
    i_host.set_reset_pin(1'b1);
    wait_ready(12);
  endtask

  task t_hold();
    wr_status(8'h01);
    check(workWord0[sfr_pkg::STAT_HOLD_SEL], 1'b1, "hold sel");
    i_host.set_reset_pin(1'b0);
    watch(3);
    check(seenFull, 1'b0, "hold no reset");
    check(holdActive, 1'b1, "hold");
    i_host.send_byte(sfr_pkg::CMD_RST_EN, 1'b0);
    i_host.send_byte(sfr_pkg::CMD_RST, 1'b0);
    watch(4);
    i_host.deselect();
    check(seenSoft, 1'b0, "refused");
    wr_status(8'h00);
  endtask

  task t_quad();
    wr_status(8'h02);
    check(quadMode, 1'b1, "quad on");
    i_host.set_reset_pin(1'b0);
    watch(3);
    check(seenFull, 1'b0, "pin lost");
    i_host.set_reset_pin(1'b1);
    i_host.send_byte(sfr_pkg::CMD_RST_EN, 1'b1);
    i_host.send_byte(sfr_pkg::CMD_RST, 1'b1);
    watch(4);
    i_host.deselect();
    check(seenSoft, 1'b1, "quad soft");
    i_host.inband_reset(1'b0);
    watch(4);
    check(seenFull, 1'b1, "quad in-band");
    wait_ready(12);
    check(quadMode, 1'b1, "reloaded");
  endtask

  // Mid-run power-on reset, then a pin reset that a low enable must ignore
  task t_freeze();
    resetn = 1'b0;
    repeat (2) @(negedge sys_clk);
    check(devReady, 1'b0, "ready in reset");
    check(workWord0, 16'h0000, "word0 in reset");
    resetn = 1'b1;
    wait_ready(12);
    check(quadMode, 1'b0, "power-on quad");
    check(workWord0, sfr_pkg::CFG_RESET_WORD, "power-on word0");
    ce = 1'b0;
    i_host.set_reset_pin(1'b0);
    watch(3);
    check(seenFull, 1'b0, "frozen pin");
    check(seenDrop, 1'b0, "frozen ready");
    i_host.set_reset_pin(1'b1);
    ce = 1'b1;
    watch(3);
    check(seenFull, 1'b0, "thawed");
    check(seenDrop, 1'b0, "thawed ready");
  endtask

  task give_verdict();
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    resetn = 1'b0;
    ce = 1'b1;
    engineStall = 1'b0;
    n_errors = 0;
    total_checks = 0;
    cycles = 0;
    repeat (2) @(negedge sys_clk);
    resetn = 1'b1;
    @(negedge sys_clk);
    t_power_up();
    t_inband();
    t_soft();
    t_pin();
    t_hold();
    t_quad();
    t_freeze();
    give_verdict();
  end
endmodule
